/* core/pmrf_defines.svh */
// Constants for the power mode and reset flag block
`ifndef PMRF_DEFINES_SVH
`define PMRF_DEFINES_SVH
`define PMRF_POWER_CONTROL_ADDR     8'h87
`define PMRF_RSTC_ADDR     8'hEF
`define PMRF_OSC_ADDR      8'hB2
`define PMRF_REGC_ADDR     8'hC9
`define PMRF_POWER_CONTROL_RESET    8'h00
`define PMRF_BIT_IDLE      0
`define PMRF_BIT_STOP      1
`define PMRF_BIT_PIN       0
`define PMRF_BIT_POR       1
`define PMRF_BIT_MCD       2
`define PMRF_BIT_WDT       3
`define PMRF_BIT_SW        4
`define PMRF_BIT_CMP       5
`define PMRF_BIT_FLASH     6
`define PMRF_BIT_SUSPEND   5
`define PMRF_BIT_REGSTOP   1
`define PMRF_MCD_TIME_US   100
`define PMRF_CLK_MHZ       100
`define PMRF_MCD_CYCLES    (`PMRF_MCD_TIME_US * `PMRF_CLK_MHZ)
`endif

/* core/pmrf_pkg.sv */
// Types for the power mode and reset flag block
package pmrf_pkg;
  typedef enum logic [2:0] {
    PMRF_RUN     = 3'b000,
    PMRF_IDLE    = 3'b001,
    PMRF_STOP    = 3'b010,
    PMRF_SUSPEND = 3'b011,
    PMRF_RESET   = 3'b100
  } pmrf_mode_t;
  typedef enum logic [2:0] {
    PMRF_C_NONE  = 3'b000,
    PMRF_C_PIN   = 3'b001,
    PMRF_C_POR   = 3'b010,
    PMRF_C_MCD   = 3'b011,
    PMRF_C_WDT   = 3'b100,
    PMRF_C_SW    = 3'b101,
    PMRF_C_CMP   = 3'b110,
    PMRF_C_FLASH = 3'b111
  } pmrf_cause_t;
endpackage

/* core/pmrf_if.sv */
// Special-register port between core and power block
`timescale 1ns/1ns
interface pmrf_if;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       core_halt;
  logic       sys_reset;
  modport dev  (input wr, rd, addr, wdata, output rdata, core_halt, sys_reset);
  modport core (output wr, rd, addr, wdata, input rdata, core_halt, sys_reset);
endinterface

/* core/pmrf_device.sv */
// Power mode control and reset cause recording
`timescale 1ns/1ns
`include "pmrf_defines.svh"
module pmrf_device #(
  parameter int MCD_CYCLES = `PMRF_MCD_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_b,
  pmrf_if.dev       bus,
  input  wire logic pin_reset,
  input  wire logic por_event,
  input  wire logic vdd_low,
  input  wire logic wdt_overflow,
  input  wire logic flash_error,
  input  wire logic cmp_out,
  input  wire logic cmp_enabled,
  input  wire logic port_match,
  input  wire logic t3_overflow,
  input  wire logic irq_pending,
  input  wire logic sysclk_active,
  output logic      periph_clk_en,
  output logic      fast_osc_en,
  output logic      regulator_off,
  output logic      mode_idle,
  output logic      mode_stop,
  output logic      mode_suspend
);
  pmrf_pkg::pmrf_mode_t  mode;
  pmrf_pkg::pmrf_mode_t  next_mode;
  pmrf_pkg::pmrf_cause_t cause;
  logic [5:0]  general_flags;
  logic        cmp_en;
  logic        mcd_en;
  logic        vdm_en;
  logic        regulator_stop_config;
  logic [15:0] mcd_count;
  logic        mcd_trip;
  logic        reset_req;
  logic [6:0]  reset_cause;
  pmrf_pkg::pmrf_cause_t req_cause;

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = bus.wr && (bus.addr == a);
  endfunction

  // Clock-loss detector sees stalls of the system clock; it counts in every mode, but its trip is ignored while the regulator is off
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mcd_count <= 16'h0000;
    end else if (!mcd_en || sysclk_active) begin
      mcd_count <= 16'h0000;
    end else if (mcd_count < 16'(MCD_CYCLES)) begin
      mcd_count <= mcd_count + 16'h0001;
    end
  end
  assign mcd_trip = mcd_en && (mcd_count >= 16'(MCD_CYCLES));

  // Cause priority: pin and power first; regulator off blocks internal sources
  always_comb begin
    req_cause = pmrf_pkg::PMRF_C_NONE;
    if (pin_reset) begin
      req_cause = pmrf_pkg::PMRF_C_PIN;
    end else if (por_event || (vdm_en && vdd_low)) begin
      req_cause = pmrf_pkg::PMRF_C_POR;
    end else if (regulator_off) begin
      req_cause = pmrf_pkg::PMRF_C_NONE;
    end else if (mcd_trip) begin
      req_cause = pmrf_pkg::PMRF_C_MCD;
    end else if (wdt_overflow) begin
      req_cause = pmrf_pkg::PMRF_C_WDT;
    end else if (wr_at(`PMRF_RSTC_ADDR) && bus.wdata[`PMRF_BIT_SW]) begin
      req_cause = pmrf_pkg::PMRF_C_SW;
    end else if (cmp_en && !cmp_out) begin
      req_cause = pmrf_pkg::PMRF_C_CMP;
    end else if (flash_error) begin
      req_cause = pmrf_pkg::PMRF_C_FLASH;
    end
  end
  assign reset_req = (req_cause != pmrf_pkg::PMRF_C_NONE);

  // Mode machine
  always_comb begin
    next_mode = mode;
    case (mode)
      pmrf_pkg::PMRF_RUN: begin
        if (reset_req) begin
          next_mode = pmrf_pkg::PMRF_RESET;
        end else if (wr_at(`PMRF_POWER_CONTROL_ADDR) && bus.wdata[`PMRF_BIT_STOP]) begin
          next_mode = pmrf_pkg::PMRF_STOP;
        end else if (wr_at(`PMRF_POWER_CONTROL_ADDR) && bus.wdata[`PMRF_BIT_IDLE]) begin
          next_mode = pmrf_pkg::PMRF_IDLE;
        end else if (wr_at(`PMRF_OSC_ADDR) && bus.wdata[`PMRF_BIT_SUSPEND]) begin
          next_mode = pmrf_pkg::PMRF_SUSPEND;
        end
      end
      pmrf_pkg::PMRF_IDLE: begin
        if (reset_req) begin
          next_mode = pmrf_pkg::PMRF_RESET;
        end else if (irq_pending) begin
          next_mode = pmrf_pkg::PMRF_RUN;
        end
      end
      pmrf_pkg::PMRF_STOP: begin
        if (reset_req) begin
          next_mode = pmrf_pkg::PMRF_RESET;
        end
      end
      pmrf_pkg::PMRF_SUSPEND: begin
        if (reset_req) begin
          next_mode = pmrf_pkg::PMRF_RESET;
        end else if (port_match || t3_overflow || (cmp_enabled && !cmp_out)) begin
          next_mode = pmrf_pkg::PMRF_RUN;
        end
      end
      pmrf_pkg::PMRF_RESET: begin
        if (!reset_req) begin
          next_mode = pmrf_pkg::PMRF_RUN;
        end
      end
      default: next_mode = pmrf_pkg::PMRF_RESET;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode <= pmrf_pkg::PMRF_RESET;
    end else begin
      mode <= next_mode;
    end
  end

  // Cause latch: held at the last request so only that flag reads one
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cause <= pmrf_pkg::PMRF_C_POR;
    end else if (reset_req) begin
      cause <= req_cause;
    end
  end

  // Enables; the supply monitor enable survives all but power resets
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cmp_en <= 1'b0;
      mcd_en <= 1'b0;
      vdm_en <= 1'b1;
    end else if (reset_req) begin
      cmp_en <= 1'b0;
      mcd_en <= 1'b0;
      if (req_cause == pmrf_pkg::PMRF_C_POR) begin
        vdm_en <= 1'b1;
      end
    end else if (wr_at(`PMRF_RSTC_ADDR)) begin
      cmp_en <= bus.wdata[`PMRF_BIT_CMP];
      mcd_en <= bus.wdata[`PMRF_BIT_MCD];
      vdm_en <= bus.wdata[`PMRF_BIT_POR];
    end
  end

  // General flags and regulator config keep their data across idle and suspend
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      general_flags         <= 6'h00;
      regulator_stop_config <= 1'b0;
    end else if (reset_req) begin
      general_flags         <= 6'h00;
      regulator_stop_config <= 1'b0;
    end else begin
      if (wr_at(`PMRF_POWER_CONTROL_ADDR)) begin
        general_flags <= bus.wdata[7:2];
      end
      if (wr_at(`PMRF_REGC_ADDR)) begin
        regulator_stop_config <= bus.wdata[`PMRF_BIT_REGSTOP];
      end
    end
  end

  // A power reset leaves the other flags undefined; they read zero here
  always_comb begin
    reset_cause = 7'h00;
    case (cause)
      pmrf_pkg::PMRF_C_PIN:   reset_cause[`PMRF_BIT_PIN] = 1'b1;
      pmrf_pkg::PMRF_C_POR:   reset_cause[`PMRF_BIT_POR] = 1'b1;
      pmrf_pkg::PMRF_C_MCD:   reset_cause[`PMRF_BIT_MCD] = 1'b1;
      pmrf_pkg::PMRF_C_WDT:   reset_cause[`PMRF_BIT_WDT] = 1'b1;
      pmrf_pkg::PMRF_C_SW:    reset_cause[`PMRF_BIT_SW] = 1'b1;
      pmrf_pkg::PMRF_C_CMP:   reset_cause[`PMRF_BIT_CMP] = 1'b1;
      pmrf_pkg::PMRF_C_FLASH: reset_cause[`PMRF_BIT_FLASH] = 1'b1;
      default:                reset_cause = 7'h00;
    endcase
  end

  // Registered read data and outputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus.rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        `PMRF_POWER_CONTROL_ADDR: bus.rdata <= {general_flags, 2'b00};
        `PMRF_RSTC_ADDR: bus.rdata <= {1'b0, reset_cause};
        `PMRF_REGC_ADDR: bus.rdata <= {6'h00, regulator_stop_config, 1'b0};
        default:         bus.rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus.core_halt <= 1'b1;
      bus.sys_reset <= 1'b1;
      periph_clk_en <= 1'b0;
      fast_osc_en   <= 1'b1;
      regulator_off <= 1'b0;
      mode_idle     <= 1'b0;
      mode_stop     <= 1'b0;
      mode_suspend  <= 1'b0;
    end else begin
      bus.core_halt <= (next_mode != pmrf_pkg::PMRF_RUN);
      bus.sys_reset <= (next_mode == pmrf_pkg::PMRF_RESET);
      periph_clk_en <= (next_mode == pmrf_pkg::PMRF_RUN) ||
                       (next_mode == pmrf_pkg::PMRF_IDLE);
      fast_osc_en   <= (next_mode != pmrf_pkg::PMRF_STOP) &&
                       (next_mode != pmrf_pkg::PMRF_SUSPEND);
      regulator_off <= (next_mode == pmrf_pkg::PMRF_STOP) &&
                       regulator_stop_config && !reset_req;
      mode_idle     <= (next_mode == pmrf_pkg::PMRF_IDLE);
      mode_stop     <= (next_mode == pmrf_pkg::PMRF_STOP);
      mode_suspend  <= (next_mode == pmrf_pkg::PMRF_SUSPEND);
    end
  end
endmodule // pmrf_device

/* core/pmrf_core_end.sv */
// Core side: issues register reads and writes one at a time
`timescale 1ns/1ns
`include "pmrf_defines.svh"
module pmrf_core_end (
  input  wire logic       clock,
  input  wire logic       rst_b,
  pmrf_if.core            bus,
  input  wire logic       req_valid,
  input  wire logic       req_write,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_data,
  output logic            req_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            halted,
  output logic            in_reset
);
  logic rd_pending;

  // Plain writes only; the user supplies whole values, no read-modify-write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
      bus.addr  <= 8'h00;
      bus.wdata <= 8'h00;
      rd_pending <= 1'b0;
    end else begin
      bus.wr <= req_valid && req_ready && req_write;
      bus.rd <= req_valid && req_ready && !req_write;
      // Read data lands one edge after the strobe, so the response trails it by one
      rd_pending <= bus.rd;
      if (req_valid && req_ready) begin
        bus.addr  <= req_addr;
        bus.wdata <= req_data;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      halted    <= 1'b1;
      in_reset  <= 1'b1;
    end else begin
      req_ready <= !bus.core_halt && !bus.sys_reset && !(req_valid && req_ready);
      rsp_valid <= rd_pending;
      rsp_data  <= bus.rdata;
      halted    <= bus.core_halt;
      in_reset  <= bus.sys_reset;
    end
  end
endmodule // pmrf_core_end

/* test/pmrf_checker.sv */
// Checker for the register port between the two ends
`timescale 1ns/1ns
module pmrf_checker (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       core_halt,
  input wire logic       sys_reset
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_idle_halts: assert property (wr && addr == 8'h87 && wdata[0] |=> core_halt)
    else $error("idle write did not halt core");
  a_stop_halts: assert property (wr && addr == 8'h87 && wdata[1] |=> core_halt)
    else $error("stop write did not halt core");
  a_suspend_halts: assert property (wr && addr == 8'hB2 && wdata[5] |=> core_halt)
    else $error("suspend write did not halt core");
  a_sw_reset: assert property (wr && addr == 8'hEF && wdata[4] |=> ##[0:3] sys_reset)
    else $error("software reset not raised");
  a_mode_bits_zero: assert property (rd && addr == 8'h87 |=> rdata[1:0] == 2'h0)
    else $error("mode select bits read nonzero");
  a_cause_top_zero: assert property (rd && addr == 8'hEF |=> !rdata[7])
    else $error("unused cause bit read one");
  a_unmapped_zero: assert property
    (rd && !(addr inside {8'h87, 8'hEF, 8'hB2, 8'hC9}) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_halt_in_reset: assert property (sys_reset |-> core_halt)
    else $error("core running during reset");
  // A system reset leaves the read register alone; sys_reset is excused all the same
  a_rdata_stands: assert property (!rd && !sys_reset |=> $stable(rdata) || sys_reset)
    else $error("read data changed without a read");
  a_strobe_single: assert property (wr |=> !wr && !rd)
    else $error("requests closer than two cycles");
endmodule // pmrf_checker

/* test/test_power_mode_and_reset_flags.sv */
// Self-checking bench joining both ends of the power block
`timescale 1ns/1ns
module test_power_mode_and_reset_flags;
  logic       clock = 1'b0;
  logic       rst_b = 1'b0;
  logic       req_valid = 1'b0, req_write = 1'b0, irq_pending = 1'b0, cmp_on = 1'b1;
  logic [7:0] req_addr = 8'h00, req_data = 8'h00, rsp_data, v;
  logic [5:0] flt = 6'h00;
  logic [2:0] wk = 3'h0;
  logic       req_ready, rsp_valid, halted, in_reset, periph_clk_en, fast_osc_en;
  logic       regulator_off, mode_idle, mode_stop, mode_suspend;
  logic [7:0] q[$];
  logic [7:0] pre[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h20};
  logic [7:0] exp_c[6] = '{8'h01, 8'h02, 8'h08, 8'h40, 8'h04, 8'h20};
  int         err_count = 0, checked = 0;
  pmrf_if bus ();
  always #5 clock = ~clock;
  // Short clock-loss count keeps the detector test brief
  pmrf_device #(.MCD_CYCLES(20)) pmrf_device_i (.clock(clock), .rst_b(rst_b), .bus(bus),
    .pin_reset(flt[0]), .por_event(1'b0), .vdd_low(flt[1]), .wdt_overflow(flt[2]),
    .flash_error(flt[3]), .cmp_out(~(flt[5] | wk[2])), .cmp_enabled(cmp_on),
    .port_match(wk[0]), .t3_overflow(wk[1]), .irq_pending(irq_pending),
    .sysclk_active(~flt[4]), .periph_clk_en(periph_clk_en), .fast_osc_en(fast_osc_en),
    .regulator_off(regulator_off), .mode_idle(mode_idle), .mode_stop(mode_stop),
    .mode_suspend(mode_suspend));
  pmrf_core_end pmrf_core_end_i (.clock(clock), .rst_b(rst_b), .bus(bus),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .halted(halted), .in_reset(in_reset));
  pmrf_checker pmrf_checker_i (.clock(clock), .rst_b(rst_b), .wr(bus.wr), .rd(bus.rd),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .core_halt(bus.core_halt),
    .sys_reset(bus.sys_reset));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task waitv(input bit h, input logic e);
    int n;
    n = 0;
    while ((h ? halted : in_reset) !== e && n < 300) begin
      @(posedge clock);
      n++;
    end
    if (n == 300) chk("level wait", 8'h01, 8'h00);
  endtask
  // Leading edge keeps two requests from landing in one time step
  task req(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    waitv(0, 1'b0);
    while (req_ready !== 1'b1) @(posedge clock);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_data <= d;
    @(posedge clock);
    while (req_ready !== 1'b1) @(posedge clock);
    req_valid <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    req(1'b0, a, 8'h00);
    repeat (4) @(posedge clock);
  endtask
  always @(posedge clock) begin
    if (rsp_valid === 1'b1 && q.size() > 0) chk("rsp_data", rsp_data, q.pop_front());
  end
  task results;
    // A read that never answered leaves its note behind
    chk("pending reads", 8'(q.size()), 8'h00);
    $display("Counts: checked %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(46833));
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    rd(8'hEF, 8'h02);
    rd(8'h87, 8'h00);
    rd(8'h10, 8'h00);
    $display("test reset done");
    // Clock loss is taken from stop, so the detector is seen to end it
    for (int i = 0; i < 6; i++) begin
      if (pre[i] != 8'h00) req(1'b1, 8'hEF, pre[i]);
      req(1'b1, 8'h87, (i == 0 || i == 4) ? 8'h02 : 8'h01);
      waitv(1, 1'b1);
      flt <= 6'(1 << i);
      waitv(0, 1'b1);
      flt <= 6'h00;
      waitv(0, 1'b0);
      rd(8'hEF, exp_c[i]);
    end
    $display("test reset causes done");
    v = 8'($urandom);
    req(1'b1, 8'h87, {v[7:2], 2'h1});
    waitv(1, 1'b1);
    repeat (2) @(posedge clock);
    chk("mode_idle", {7'h00, mode_idle}, 8'h01);
    chk("periph_clk_en", {7'h00, periph_clk_en}, 8'h01);
    irq_pending <= 1'b1;
    waitv(1, 1'b0);
    irq_pending <= 1'b0;
    chk("in_reset", {7'h00, in_reset}, 8'h00);
    rd(8'h87, {v[7:2], 2'h0});
    $display("test idle done");
    req(1'b1, 8'hEF, 8'h10);
    waitv(0, 1'b1);
    waitv(0, 1'b0);
    rd(8'hEF, 8'h10);
    req(1'b1, 8'hEF, 8'h49);
    rd(8'hEF, 8'h10);
    $display("test software reset done");
    req(1'b1, 8'hC9, 8'h02);
    chk("fast_osc_en", {7'h00, fast_osc_en}, 8'h01);
    req(1'b1, 8'h87, 8'h02);
    waitv(1, 1'b1);
    repeat (2) @(posedge clock);
    chk("regulator_off", {7'h00, regulator_off}, 8'h01);
    chk("mode_stop", {7'h00, mode_stop}, 8'h01);
    chk("fast_osc_en", {7'h00, fast_osc_en}, 8'h00);
    chk("periph_clk_en", {7'h00, periph_clk_en}, 8'h00);
    flt <= 6'h04;
    repeat (5) @(posedge clock);
    flt <= 6'h01;
    chk("in_reset", {7'h00, in_reset}, 8'h00);
    waitv(0, 1'b1);
    flt <= 6'h00;
    waitv(0, 1'b0);
    rd(8'hEF, 8'h01);
    $display("test regulator stop done");
    // Last pass holds a low comparator while it is disabled: no wake until enabled
    for (int j = 0; j < 4; j++) begin
      req(1'b1, 8'hB2, 8'h20);
      waitv(1, 1'b1);
      repeat (2) @(posedge clock);
      chk("mode_suspend", {7'h00, mode_suspend}, 8'h01);
      chk("fast_osc_en", {7'h00, fast_osc_en}, 8'h00);
      if (j == 3) begin
        cmp_on <= 1'b0;
        wk <= 3'h4;
        repeat (8) @(posedge clock);
        chk("mode_suspend", {7'h00, mode_suspend}, 8'h01);
        cmp_on <= 1'b1;
      end else begin
        wk <= 3'(1 << j);
      end
      waitv(1, 1'b0);
      wk <= 3'h0;
      chk("in_reset", {7'h00, in_reset}, 8'h00);
    end
    $display("test suspend done");
    results();
  end
  initial begin
    repeat (20000) @(posedge clock);
    chk("watchdog", 8'h01, 8'h00);
    results();
  end
endmodule // test_power_mode_and_reset_flags
